// [rtl/uart_regs_pkg.sv]
package uart_regs_pkg;

	// register index; byte address is four times the index
	localparam logic [3:0] IDX_DIV_LO = 4'h0;
	localparam logic [3:0] IDX_DIV_HI = 4'h1;
	localparam logic [3:0] IDX_ALT = 4'h2;
	localparam logic [3:0] IDX_LINE_CTL = 4'h3;
	localparam logic [3:0] IDX_MODEM_CTL = 4'h4;
	localparam logic [3:0] IDX_LINE_STAT = 4'h5;
	localparam logic [3:0] IDX_MODEM_STAT = 4'h6;
	localparam logic [3:0] IDX_SCRATCH = 4'h7;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
	localparam logic [3:0] IDX_IRQ_CLR = 4'h9;
	localparam logic [3:0] IDX_IRQ_EN = 4'ha;
	localparam logic [3:0] IDX_LAST = 4'ha;

	localparam logic [7:0] ENH_KEY = 8'hbf;
	localparam int LC_DIV_EN = 7;
	localparam int FEAT_SWAP = 6;
	localparam int ENH_UNLOCK = 4;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam logic [1:0] CNT_SEL_TX = 2'h1;

	// bits that exist only while the unlock bit is set; ALT_WR_MASK keeps the writable alternate function bits
	localparam logic [7:0] IEN_EXT_MASK = 8'hf0;
	localparam logic [7:0] ISTAT_EXT_MASK = 8'h30;
	localparam logic [7:0] FIFO_EXT_MASK = 8'h30;
	localparam logic [7:0] MC_EXT_MASK = 8'he0;
	localparam logic [7:0] ALT_WR_MASK = 8'h07;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'hff;
	localparam logic [7:0] RST_MODE_SEL = 8'h80;
	localparam logic [3:0] RST_PINS_N = 4'hf;

	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_in_t;

	typedef struct packed {
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] alt_fn;
		logic [7:0] line_ctl;
		logic [7:0] modem_ctl;
		logic [7:0] scratch;
		logic [7:0] mode_sel;
		logic [7:0] trig_level;
		logic [7:0] feat_ctl;
		logic [7:0] enh_fn;
		logic [7:0] resume_one;
		logic [7:0] resume_two;
		logic [7:0] pause_one;
		logic [7:0] pause_two;
		logic [7:0] int_enable;
		logic [7:0] fifo_ctl;
	} cfg_t;

	typedef struct packed {
		cfg_t cfg;
		logic [7:0] tx_data;
		logic tx_strobe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic dtr_n;
		logic rts_n;
		logic out2_n;
		logic irq;
		logic [7:0] irq_en;
		logic [3:0] mprev;
		logic [7:0] lprev;
	} regs_st_t;

	localparam cfg_t CFG_RST = '{scratch: RST_SCRATCH, mode_sel: RST_MODE_SEL, default: RST_ZERO};
	localparam regs_st_t ST_RST = '{cfg: CFG_RST, dtr_n: 1'b1, rts_n: 1'b1, out2_n: 1'b1,
		default: '0};

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync
	import uart_regs_pkg::*;
#(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_st_t;

	sync_st_t s;
	sync_st_t n;

	always_comb begin
		n.s1 = d;
		n.s2 = s.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= {RST_VAL, RST_VAL};
		end else begin
			s <= n;
		end
	end

	assign q = s.s2;
endmodule

// [rtl/sticky_flags.sv]
`timescale 1ns/1ns
module sticky_flags
	import uart_regs_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] flags;
	} flag_st_t;

	flag_st_t s;
	flag_st_t n;

	// a set in the clearing cycle survives
	always_comb begin
		n.flags = (s.flags & ~clr) | set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.flags;
endmodule

// [rtl/uart_channel_regs.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
module uart_channel_regs
	import uart_regs_pkg::*;
#(
	parameter logic [7:0] REV_CODE = 8'h11, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h5c // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] line_status_in,
	input wire logic [7:0] int_status_in,
	input wire logic [7:0] rx_data,
	input wire logic [7:0] rx_count,
	input wire logic [7:0] tx_count,
	input wire modem_in_t modem_in_n,
	output cfg_t cfg,
	output logic [7:0] tx_data,
	output logic tx_strobe,
	output logic dtr_n,
	output logic rts_n,
	output logic general_output_two_n,
	output logic irq
);
	regs_st_t s;
	regs_st_t n;

	logic [3:0] idx;
	logic valid;
	logic setup;
	logic access;
	logic wr;
	logic [7:0] wv;
	logic enh;
	logic div;
	logic unlock;
	logic swap;
	logic div_zero;
	logic [7:0] fifo_lvl;
	logic [3:0] pins_q;
	logic [3:0] mstate;
	logic [3:0] delta;
	logic [3:0] mdelta_q;
	logic [3:0] mdelta_clr;
	logic [7:0] events;
	logic [7:0] irq_q;
	logic [7:0] irq_clr;
	logic [7:0] rv;

	pin_sync #(.W(4), .RST_VAL(RST_PINS_N)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(modem_in_n),
		.q(pins_q)
	);

	sticky_flags #(.W(4)) u_delta (
		.pclk(pclk),
		.presetn(presetn),
		.set(delta),
		.clr(mdelta_clr),
		.q(mdelta_q)
	);

	sticky_flags #(.W(8)) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.set(events),
		.clr(irq_clr),
		.q(irq_q)
	);

	assign idx = paddr[5:2];
	assign valid = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx <= IDX_LAST);
	assign setup = psel & ~penable;
	assign access = psel & penable & s.pready;
	assign wr = access & pwrite & valid;
	assign wv = pwdata[7:0];

	assign enh = (s.cfg.line_ctl == ENH_KEY);
	assign div = s.cfg.line_ctl[LC_DIV_EN] & ~enh;
	assign unlock = s.cfg.enh_fn[ENH_UNLOCK];
	assign swap = s.cfg.feat_ctl[FEAT_SWAP];
	assign div_zero = (s.cfg.div_lo == RST_ZERO) && (s.cfg.div_hi == RST_ZERO);
	assign fifo_lvl = (s.cfg.mode_sel[1:0] == CNT_SEL_TX) ? tx_count : rx_count;

	// loopback feeds the control outputs back as modem inputs
	always_comb begin
		if (s.cfg.modem_ctl[MC_LOOP]) begin
			mstate = {s.cfg.modem_ctl[MC_OUT2], s.cfg.modem_ctl[MC_OUT1],
				s.cfg.modem_ctl[MC_DTR], s.cfg.modem_ctl[MC_RTS]};
		end else begin
			mstate = ~pins_q;
		end
	end

	assign delta = mstate ^ s.mprev;
	assign events = {line_status_in[4:1] & ~s.lprev[4:1], delta};
	// only the change flags that were actually returned are cleared
	assign mdelta_clr = (access && !pwrite && valid && idx == IDX_MODEM_STAT && !enh) ?
		s.prdata[3:0] : 4'h0;
	assign irq_clr = (wr && idx == IDX_IRQ_CLR) ? wv : 8'h00;

	function automatic logic [7:0] keep_mask(input logic [7:0] m, input logic unl);
		keep_mask = unl ? 8'hff : ~m;
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m, input logic unl);
		logic [7:0] k;
		k = keep_mask(m, unl);
		merge = (nw & k) | (old & ~k);
	endfunction

	// read value at the setup cycle
	always_comb begin
		rv = 8'h00;
		unique case (idx)
			IDX_DIV_LO: begin
				if (enh) begin
					rv = fifo_lvl;
				end else if (div) begin
					rv = div_zero ? REV_CODE : s.cfg.div_lo;
				end else begin
					rv = rx_data;
				end
			end
			IDX_DIV_HI: begin
				if (enh) begin
					rv = s.cfg.feat_ctl;
				end else if (div) begin
					rv = div_zero ? DEV_ID : s.cfg.div_hi;
				end else begin
					rv = s.cfg.int_enable & keep_mask(IEN_EXT_MASK, unlock);
				end
			end
			IDX_ALT: begin
				if (enh) begin
					rv = s.cfg.enh_fn;
				end else if (div) begin
					rv = s.cfg.alt_fn;
				end else begin
					rv = int_status_in & keep_mask(ISTAT_EXT_MASK, unlock);
				end
			end
			IDX_LINE_CTL: rv = s.cfg.line_ctl;
			IDX_MODEM_CTL: begin
				rv = enh ? s.cfg.resume_one :
					(s.cfg.modem_ctl & keep_mask(MC_EXT_MASK, unlock));
			end
			IDX_LINE_STAT: rv = enh ? s.cfg.resume_two : line_status_in;
			IDX_MODEM_STAT: rv = enh ? s.cfg.pause_one : {mstate, mdelta_q};
			IDX_SCRATCH: begin
				if (enh) begin
					rv = s.cfg.pause_two;
				end else begin
					rv = swap ? fifo_lvl : s.cfg.scratch;
				end
			end
			IDX_IRQ_STAT: rv = irq_q;
			IDX_IRQ_EN: rv = s.irq_en;
			default: rv = 8'h00;
		endcase
	end

	always_comb begin
		n = s;
		n.pready = 1'b0;
		n.tx_strobe = 1'b0;
		n.mprev = mstate;
		n.lprev = line_status_in;
		if (setup) begin
			n.pready = 1'b1;
			n.pslverr = ~valid;
			n.prdata = valid ? {24'h000000, rv} : 32'h00000000;
		end
		if (wr) begin
			unique case (idx)
				IDX_DIV_LO: begin
					if (enh) begin
						n.cfg.trig_level = wv;
					end else if (div) begin
						n.cfg.div_lo = wv;
					end else begin
						n.tx_data = wv;
						n.tx_strobe = 1'b1;
					end
				end
				IDX_DIV_HI: begin
					if (enh) begin
						n.cfg.feat_ctl = wv;
					end else if (div) begin
						n.cfg.div_hi = wv;
					end else begin
						n.cfg.int_enable = merge(s.cfg.int_enable, wv, IEN_EXT_MASK, unlock);
					end
				end
				IDX_ALT: begin
					if (enh) begin
						n.cfg.enh_fn = wv;
					end else if (div) begin
						n.cfg.alt_fn = wv & ALT_WR_MASK;
					end else begin
						n.cfg.fifo_ctl = merge(s.cfg.fifo_ctl, wv, FIFO_EXT_MASK, unlock);
					end
				end
				IDX_LINE_CTL: n.cfg.line_ctl = wv;
				IDX_MODEM_CTL: begin
					if (enh) begin
						n.cfg.resume_one = wv;
					end else begin
						n.cfg.modem_ctl = merge(s.cfg.modem_ctl, wv, MC_EXT_MASK, unlock);
					end
				end
				IDX_LINE_STAT: begin
					if (enh) begin
						n.cfg.resume_two = wv;
					end
				end
				IDX_MODEM_STAT: begin
					if (enh) begin
						n.cfg.pause_one = wv;
					end
				end
				IDX_SCRATCH: begin
					if (enh) begin
						n.cfg.pause_two = wv;
					end else if (swap) begin
						n.cfg.mode_sel = wv;
					end else begin
						n.cfg.scratch = wv;
					end
				end
				IDX_IRQ_EN: n.irq_en = wv;
				default: n.irq_en = s.irq_en;
			endcase
		end
		// pins are inactive while looped back
		n.dtr_n = ~(n.cfg.modem_ctl[MC_DTR] & ~n.cfg.modem_ctl[MC_LOOP]);
		n.rts_n = ~(n.cfg.modem_ctl[MC_RTS] & ~n.cfg.modem_ctl[MC_LOOP]);
		n.out2_n = ~(n.cfg.modem_ctl[MC_OUT2] & ~n.cfg.modem_ctl[MC_LOOP]);
		n.irq = |(irq_q & s.irq_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign cfg = s.cfg;
	assign tx_data = s.tx_data;
	assign tx_strobe = s.tx_strobe;
	assign dtr_n = s.dtr_n;
	assign rts_n = s.rts_n;
	assign general_output_two_n = s.out2_n;
	assign irq = s.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_ready_pulse;
		s.pready ##1 !s.pready;
	endsequence

	a_apb_ready: assert property (s_setup |=> s_ready_pulse)
		else $error("ready not a one-cycle pulse after setup");
	a_line_ctl_wr: assert property (wr && idx == IDX_LINE_CTL |=>
		s.cfg.line_ctl == $past(wv))
		else $error("line control write lost");
	a_modem_pins: assert property (s.dtr_n ==
		~(s.cfg.modem_ctl[MC_DTR] & ~s.cfg.modem_ctl[MC_LOOP]))
		else $error("terminal ready pin wrong");
	a_line_stat_rd: assert property (setup && valid && idx == IDX_LINE_STAT && !enh |=>
		s.prdata[7:0] == $past(line_status_in) && s.pready)
		else $error("line status read wrong");
	a_modem_delta: assert property (delta != 4'h0 |=> (mdelta_q & $past(delta)) == $past(delta))
		else $error("modem change not latched");
	a_swap_write: assert property (wr && idx == IDX_SCRATCH && !enh && swap |=>
		s.cfg.mode_sel == $past(wv) && $stable(s.cfg.scratch))
		else $error("swapped write went to scratch");
	a_div_access: assert property (wr && idx == IDX_DIV_LO && div |=>
		s.cfg.div_lo == $past(wv) && $stable(s.cfg.trig_level))
		else $error("divisor low write lost");
	a_alt_reserved: assert property (s.cfg.alt_fn[7:3] == 5'h00)
		else $error("alternate function reserved bits set");
	a_rev_read: assert property (setup && valid && idx == IDX_DIV_LO && div && div_zero |=>
		s.prdata[7:0] == REV_CODE)
		else $error("revision code not returned");
	a_enh_char: assert property (wr && idx == IDX_MODEM_CTL && enh |=>
		s.cfg.resume_one == $past(wv) && $stable(s.cfg.modem_ctl))
		else $error("enhanced bank write misrouted");
	a_lock_mask: assert property (setup && valid && idx == IDX_MODEM_CTL && !enh && !unlock |=>
		s.prdata[7:5] == 3'h0)
		else $error("locked bits visible");
	a_lock_write: assert property (wr && idx == IDX_MODEM_CTL && !enh && !unlock |=>
		s.cfg.modem_ctl[7:5] == $past(s.cfg.modem_ctl[7:5]))
		else $error("locked bits written");
	a_irq_level: assert property ((|(irq_q & s.irq_en)) |=> s.irq)
		else $error("interrupt not raised");
	a_irq_quiet: assert property (!(|(irq_q & s.irq_en)) |=> !s.irq)
		else $error("interrupt without cause");
	a_dev_read: assert property (setup && valid && idx == IDX_DIV_HI && div && div_zero |=>
		s.prdata[7:0] == DEV_ID)
		else $error("identification code not returned");
	a_bad_addr: assert property (setup && !valid |=> s.pslverr && s.prdata == 32'h00000000)
		else $error("unmapped access not refused");
	a_tx_write: assert property (wr && idx == IDX_DIV_LO && !enh && !div |=>
		s.tx_strobe && s.tx_data == $past(wv))
		else $error("transmit byte not handed over");
endmodule

// [bench/apb_host.sv]
`timescale 1ns/1ns
module apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// one transfer; request held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
		output logic [7:0] q, output logic e, output logic hung);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		// pready and read data are taken only at a rising edge
		@(posedge pclk);
		while (pready !== 1'h1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		hung = (n >= 20);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

// [bench/tb_uart_channel_regs.sv]
`timescale 1ns/1ns
`define CHK(a, b) \
	begin \
		cmp_count++; \
		if ((a) !== (b)) begin \
			errors++; \
			$display("Error %0t: got %h exp %h", $time, a, b); \
		end \
	end

module tb_uart_channel_regs;
	import uart_regs_pkg::*;
	localparam logic [7:0] REV = 8'h11; // arbitrary value
	localparam logic [7:0] DEV = 8'h5c; // arbitrary value
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, lsi, isi, rxd, rxc, txc, txd, q;
	logic [31:0] pwdata, prdata;
	logic txs, dtr_n, rts_n, out2_n, irq, e, hung;
	modem_in_t pins_n;
	cfg_t cfg;
	int errors, cmp_count, n;

	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	uart_channel_regs #(.REV_CODE(REV), .DEV_ID(DEV)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_status_in(lsi),
		.int_status_in(isi), .rx_data(rxd), .rx_count(rxc), .tx_count(txc),
		.modem_in_n(pins_n), .cfg(cfg), .tx_data(txd), .tx_strobe(txs), .dtr_n(dtr_n),
		.rts_n(rts_n), .general_output_two_n(out2_n), .irq(irq));

	task automatic wrap_up;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic go(input logic w, input logic [3:0] i, input logic [7:0] d);
		host_u.xfer(w, i, d, q, e, hung);
		if (hung) begin
			errors++;
			$display("Error %0t: no bus answer", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		go(1'h1, i, d);
	endtask

	task automatic rd(input logic [3:0] i, input logic [7:0] x);
		go(1'h0, i, 8'h00);
		`CHK(q, x);
		`CHK(e, 1'h0);
	endtask

	// outputs follow a write at the same edge as it lands
	task automatic settle;
		repeat (2) @(negedge pclk);
	endtask

	task automatic wirq(input logic x);
		n = 0;
		while (irq !== x && n < 8) begin
			@(negedge pclk);
			n++;
		end
		`CHK(irq, x);
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		presetn = 1'h0;
		lsi = 8'he1;
		isi = 8'h3f;
		rxd = 8'h3c;
		rxc = 8'h29;
		txc = 8'h17;
		pins_n = 4'hf;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rd(4'h3, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h7, 8'hff);
		wr(4'h3, 8'h1b);
		rd(4'h3, 8'h1b);
		wr(4'h0, 8'h5a);
		@(negedge pclk);
		`CHK({txs, txd}, 9'h15a);
		@(negedge pclk);
		`CHK(txs, 1'h0);
		tdone("reset and line control");
		wr(4'h4, 8'heb);
		rd(4'h4, 8'h0b);
		rd(4'h2, 8'h0f);
		settle();
		`CHK({dtr_n, rts_n, out2_n}, 3'h0);
		rd(4'h5, 8'he1);
		tdone("modem control and line status");
		wr(4'ha, 8'h01);
		@(posedge pclk);
		pins_n.cts <= 1'h0;
		wirq(1'h1);
		rd(4'h8, 8'h01);
		rd(4'h6, 8'h11);
		rd(4'h6, 8'h10);
		wr(4'h9, 8'h01);
		wirq(1'h0);
		// masked event still sets status
		@(posedge pclk);
		lsi <= 8'he3;
		repeat (4) @(negedge pclk);
		`CHK(irq, 1'h0);
		rd(4'h8, 8'h10);
		wr(4'h9, 8'hff);
		tdone("interrupts");
		wr(4'h3, 8'h80);
		rd(4'h0, REV);
		rd(4'h1, DEV);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h07);
		wr(4'h0, 8'h34);
		rd(4'h0, 8'h34);
		wr(4'h1, 8'h12);
		rd(4'h1, 8'h12);
		rd(4'h3, 8'h80);
		tdone("divisor bank");
		wr(4'h3, 8'hbf);
		wr(4'h1, 8'h40);
		rd(4'h1, 8'h40);
		wr(4'h2, 8'h10);
		rd(4'h2, 8'h10);
		for (int i = 4; i < 8; i++) begin
			wr(i[3:0], 8'ha0 + 8'(i));
			rd(i[3:0], 8'ha0 + 8'(i));
		end
		wr(4'h0, 8'h77);
		settle();
		`CHK(cfg.trig_level, 8'h77);
		rd(4'h0, rxc);
		tdone("enhanced bank");
		wr(4'h3, 8'h03);
		wr(4'h7, 8'hc5);
		settle();
		`CHK(cfg.mode_sel, 8'hc5);
		rd(4'h7, txc);
		wr(4'h4, 8'heb);
		rd(4'h4, 8'heb);
		rd(4'h2, 8'h3f);
		wr(4'h4, 8'h1b);
		settle();
		`CHK({dtr_n, rts_n, out2_n}, 3'h7);
		rd(4'h6, 8'hba);
		go(1'h0, 4'hb, 8'h00);
		`CHK(e, 1'h1);
		`CHK(q, 8'h00);
		tdone("swap, unlock, loopback, unmapped");
		wrap_up();
	end
endmodule
